/* File: pkg/ihrp_pkg.sv */
package ihrp_pkg;
  // ----------------------------------------
  // Bus identity and framing
  // ----------------------------------------
  localparam logic [6:0] IHRP_TARGET_ADDR = 7'h28;
  localparam int IHRP_BYTE_BITS = 8;
  localparam logic [7:0] IHRP_PTR_RESET = 8'h00;
  localparam int IHRP_SYNC_STAGES = 2;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  // Register access request from the serial port
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } ihrp_wr_t;

  // Sampled bus line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } ihrp_lines_t;
endpackage : ihrp_pkg

/* File: rtl/ihrp_sync.sv */
`timescale 1ns/100ps
// Two-stage synchroniser for the host bus lines
module ihrp_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire ihrp_pkg::ihrp_lines_t raw,
  output ihrp_pkg::ihrp_lines_t synced
);
  import ihrp_pkg::*;
  ihrp_lines_t stage1_reg;
  ihrp_lines_t stage2_reg;

  // ----------------------------------------
  // Metastability stages
  // ----------------------------------------
  // Idle bus level is high, so reset to released lines
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_reg <= '{scl: 1'b1, sda: 1'b1};
      stage2_reg <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      stage1_reg <= raw;
      stage2_reg <= stage1_reg;
    end
  end
  assign synced = stage2_reg;
endmodule : ihrp_sync

/* File: rtl/ihrp_target.sv */
`timescale 1ns/100ps
// Operation
// RULE_01: Only the 7-bit address 0x28 (0x50 with the direction bit) is answered.
// RULE_02: Every transfer is begun by the host; this port never makes a start.
// RULE_03: Bytes move MSB first, eight bits each, on the host clock, each followed by an ack.
// RULE_04: Single and multi byte reads and writes to the register space are accepted.
// RULE_05: The host drives the clock and this port never stretches it outside bypass.
// RULE_06: Both lines are driven only open drain, low or released, never high.
// RULE_07: A write sets the pointer from the first byte then stores data at rising pointers.
// RULE_08: A combined read after a repeated start returns data from the written pointer.
// RULE_09: A pointer-only write is acked, keeps the pointer and writes nothing.
// RULE_10: A fresh read starts at the held pointer and advances one register per byte.
// RULE_11: The host event interrupt signals that new results are ready.
// RULE_12: Standard, Fast, Fast-mode Plus and High-speed bus modes work.
// RULE_13: Multi-byte values are little-endian, low byte at the low address and sent first.
// RULE_14: On an address mismatch the data line stays released and the frame is ignored.
module ihrp_target (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_bus_clock_line_i,
  output logic host_bus_clock_line_o,
  output logic host_bus_clock_line_oe_n,
  input wire logic host_bus_data_line_i,
  output logic host_bus_data_line_o,
  output logic host_bus_data_line_oe_n,
  output ihrp_pkg::ihrp_wr_t reg_wr,
  output logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  output logic reg_rd_strobe,
  input wire logic bypass_stretch,
  input wire logic results_ready,
  output logic host_event_irq,
  output logic [7:0] pointer
);
  import ihrp_pkg::*;

  typedef enum logic [2:0] {
    IHRP_IDLE, IHRP_START, IHRP_ADDR, IHRP_ADDR_ACK, IHRP_RX, IHRP_RX_ACK,
    IHRP_TX, IHRP_TX_ACK
  } ihrp_state_t;

  // ----------------------------------------
  // Line sampling and condition detect
  // ----------------------------------------
  ihrp_lines_t raw_lines;
  ihrp_lines_t lines;
  ihrp_lines_t last_reg;
  assign raw_lines = '{scl: host_bus_clock_line_i, sda: host_bus_data_line_i};

  ihrp_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .raw(raw_lines),
    .synced(lines)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) last_reg <= '{scl: 1'b1, sda: 1'b1};
    else last_reg <= lines;
  end

  // Edges are taken from the synchronised copy only
  wire scl_rise = lines.scl & ~last_reg.scl;
  wire scl_fall = ~lines.scl & last_reg.scl;
  wire start_det = lines.scl & last_reg.scl & last_reg.sda & ~lines.sda; // RULE_02
  wire stop_det = lines.scl & last_reg.scl & ~last_reg.sda & lines.sda;

  // ----------------------------------------
  // Byte engine state
  // ----------------------------------------
  ihrp_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] ptr_reg, ptr_next;
  logic first_reg, first_next;
  logic sda_low_reg, sda_low_next;
  logic wr_pulse_next;
  logic rd_pulse_next;
  logic nack_reg, nack_next;

  // Address match; the low bit of the shifted byte is the direction
  wire addr_hit = (shift_reg[7:1] == IHRP_TARGET_ADDR); // RULE_01
  wire dir_read = shift_reg[0];
  wire [7:0] ptr_inc = ptr_reg + 8'h01; // RULE_13

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    ptr_next = ptr_reg;
    first_next = first_reg;
    sda_low_next = sda_low_reg;
    wr_pulse_next = 1'b0;
    rd_pulse_next = 1'b0;
    nack_next = nack_reg;
    if (start_det) begin
      // Repeated start keeps the pointer for combined reads
      state_next = IHRP_START; // RULE_08
      bit_next = 3'd7;
      sda_low_next = 1'b0;
    end else if (stop_det) begin
      state_next = IHRP_IDLE;
      sda_low_next = 1'b0;
    end else begin
      case (state_reg)
        IHRP_START: begin
          // Clock fall that closes the start carries no bit, so it must not count
          if (scl_fall) begin
            state_next = IHRP_ADDR;
            bit_next = 3'd7;
          end
        end
        IHRP_IDLE: begin
          sda_low_next = 1'b0; // RULE_14
        end
        IHRP_ADDR, IHRP_RX: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], lines.sda}; // RULE_03
          end
          if (scl_fall && bit_reg == 3'd0) begin
            if (state_reg == IHRP_ADDR && !addr_hit) begin
              state_next = IHRP_IDLE; // RULE_14
            end else begin
              state_next = (state_reg == IHRP_ADDR) ? IHRP_ADDR_ACK : IHRP_RX_ACK;
              sda_low_next = 1'b1; // RULE_07
            end
          end else if (scl_fall) begin
            bit_next = bit_reg - 3'd1;
          end
        end
        IHRP_ADDR_ACK: begin
          if (scl_fall) begin
            bit_next = 3'd7;
            if (dir_read) begin
              state_next = IHRP_TX; // RULE_10
              shift_next = reg_rd_data;
              sda_low_next = ~reg_rd_data[7];
              rd_pulse_next = 1'b1;
            end else begin
              state_next = IHRP_RX;
              first_next = 1'b1;
              sda_low_next = 1'b0;
            end
          end
        end
        IHRP_RX_ACK: begin
          if (scl_fall) begin
            state_next = IHRP_RX;
            bit_next = 3'd7;
            sda_low_next = 1'b0;
            first_next = 1'b0;
            if (first_reg) begin
              ptr_next = shift_reg; // RULE_09
            end else begin
              wr_pulse_next = 1'b1; // RULE_07
              ptr_next = ptr_inc;
            end
          end
        end
        IHRP_TX: begin
          if (scl_fall) begin
            if (bit_reg == 3'd0) begin
              state_next = IHRP_TX_ACK;
              sda_low_next = 1'b0; // Release for the host ack
              ptr_next = ptr_inc; // RULE_10
            end else begin
              bit_next = bit_reg - 3'd1;
              shift_next = {shift_reg[6:0], 1'b0};
              sda_low_next = ~shift_reg[6]; // RULE_03
            end
          end
        end
        IHRP_TX_ACK: begin
          if (scl_rise) begin
            nack_next = lines.sda;
          end
          if (scl_fall) begin
            if (nack_reg) begin
              state_next = IHRP_IDLE; // RULE_08
            end else begin
              state_next = IHRP_TX;
              bit_next = 3'd7;
              shift_next = reg_rd_data;
              sda_low_next = ~reg_rd_data[7];
              rd_pulse_next = 1'b1;
            end
          end
        end
        default: begin
          state_next = IHRP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic wr_pulse_reg;
  logic rd_pulse_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic irq_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= IHRP_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 3'd7;
      ptr_reg <= IHRP_PTR_RESET;
      first_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      ptr_reg <= ptr_next;
      first_reg <= first_next;
      sda_low_reg <= sda_low_next;
      nack_reg <= nack_next;
    end
  end

  // Write strobe carries the address used before the pointer moved
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pulse_reg <= 1'b0;
      rd_pulse_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_pulse_reg <= wr_pulse_next;
      rd_pulse_reg <= rd_pulse_next;
      if (wr_pulse_next) begin
        wr_addr_reg <= ptr_reg; // RULE_04
        wr_data_reg <= shift_reg;
      end
    end
  end

  // Event line mirrors the results flag, registered
  always_ff @(posedge clk) begin
    if (!rst_n) irq_reg <= 1'b0;
    else irq_reg <= results_ready; // RULE_11
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open drain: output is always low, enable low means pulling
  assign host_bus_data_line_o = 1'b0; // RULE_06
  assign host_bus_data_line_oe_n = ~sda_low_reg; // RULE_06
  assign host_bus_clock_line_o = 1'b0;
  // Stretch only in bypass, during the clock low phase
  assign host_bus_clock_line_oe_n = ~(bypass_stretch & ~lines.scl); // RULE_05
  assign reg_wr = '{wr: wr_pulse_reg, addr: wr_addr_reg, data: wr_data_reg};
  assign reg_rd_addr = ptr_reg;
  assign reg_rd_strobe = rd_pulse_reg;
  assign host_event_irq = irq_reg;
  assign pointer = ptr_reg;
  // Sync plus edge logic ~20 ns; High-speed low phase is well above that at 200 MHz
  // RULE_12
endmodule : ihrp_target

/* File: sim/ihrp_host_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Bus master model, 125 ns bit time
// ----------------------------------------
module ihrp_host_model (
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  localparam realtime Q = 31.25;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Start or repeated start, only ever made here
  task automatic start();
    #Q;
    sda_low = 1'b0;
    #Q;
    scl_low = 1'b0;
    #(2*Q);
    sda_low = 1'b1;
    #(2*Q);
    scl_low = 1'b1;
  endtask : start
  task automatic stop();
    #Q;
    sda_low = 1'b1;
    #Q;
    scl_low = 1'b0;
    #(2*Q);
    sda_low = 1'b0;
    #(4*Q);
  endtask : stop
  // Direct clock pull, used to let the port hold the clock
  task automatic drive_scl(input logic v);
    scl_low = v;
  endtask : drive_scl
  // Data changes mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    #Q;
    sda_low = !b;
    #Q;
    scl_low = 1'b0;
    #Q;
    r = sda;
    #Q;
    scl_low = 1'b1;
  endtask : bit_io
  // Eight bits MSB first, then the ack slot
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(a, k);
  endtask : byte_io
endmodule : ihrp_host_model

/* File: sim/ihrp_target_sva.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module ihrp_target_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_bus_clock_line_i,
  input wire logic host_bus_clock_line_o,
  input wire logic host_bus_clock_line_oe_n,
  input wire logic host_bus_data_line_i,
  input wire logic host_bus_data_line_o,
  input wire logic host_bus_data_line_oe_n,
  input wire ihrp_pkg::ihrp_wr_t reg_wr,
  input wire logic [7:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_strobe,
  input wire logic bypass_stretch,
  input wire logic results_ready,
  input wire logic host_event_irq,
  input wire logic [7:0] pointer
);
  import ihrp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Clock is only held in the pass-through state
  property p_scl_free; !bypass_stretch |-> host_bus_clock_line_oe_n; endproperty
  a_scl_free: assert property (p_scl_free) else $error("clock held outside bypass");
  // Open drain: pin data never high
  property p_od; host_bus_clock_line_o == 1'b0 && host_bus_data_line_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_irq; 1'b1 |=> host_event_irq == $past(results_ready); endproperty
  a_irq: assert property (p_irq) else $error("event line lags");
  property p_wr_pulse; reg_wr.wr |=> !reg_wr.wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_wr_ptr; reg_wr.wr |-> ##[0:1] pointer == reg_wr.addr + 8'h01; endproperty
  a_wr_ptr: assert property (p_wr_ptr) else $error("pointer not advanced");
  property p_rd_pulse; reg_rd_strobe |=> !reg_rd_strobe; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  // A loaded byte goes out MSB first: the pin shows bit 7 of the fetched data
  property p_rd_msb;
    reg_rd_strobe |-> host_bus_data_line_oe_n == $past(reg_rd_data[7]);
  endproperty
  a_rd_msb: assert property (p_rd_msb) else $error("first read bit not MSB");
  // After a stop the data line must be free again
  property p_stop_rel;
    $rose(host_bus_data_line_i) && host_bus_clock_line_i |-> ##[0:8] host_bus_data_line_oe_n;
  endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("data held after stop");
endmodule : ihrp_target_sva
bind ihrp_target ihrp_target_sva ihrp_target_sva_inst (.clk, .rst_n, .host_bus_clock_line_i,
  .host_bus_clock_line_o, .host_bus_clock_line_oe_n, .host_bus_data_line_i, .host_bus_data_line_o,
  .host_bus_data_line_oe_n, .reg_wr, .reg_rd_addr, .reg_rd_data, .reg_rd_strobe, .bypass_stretch,
  .results_ready, .host_event_irq, .pointer);

/* File: sim/test_i2c_host_register_port.sv */
`timescale 1ns/100ps
module test_i2c_host_register_port;
  import ihrp_pkg::*;
  logic clk, rst_n, host_bus_clock_line_i, host_bus_clock_line_o, host_bus_clock_line_oe_n;
  logic host_bus_data_line_i, host_bus_data_line_o, host_bus_data_line_oe_n;
  logic reg_rd_strobe, bypass_stretch, results_ready, host_event_irq, h_scl, h_sda;
  logic [7:0] reg_rd_addr, reg_rd_data, pointer;
  logic [7:0] regs [256];
  ihrp_wr_t reg_wr;
  int fails, total_checks, wr_cnt;
  // Wired-AND lines with pull-ups
  assign host_bus_clock_line_i = !h_scl && host_bus_clock_line_oe_n;
  assign host_bus_data_line_i = !h_sda && host_bus_data_line_oe_n;
  assign reg_rd_data = regs[reg_rd_addr];
  ihrp_target ihrp_target_inst (.clk, .rst_n, .host_bus_clock_line_i, .host_bus_clock_line_o,
    .host_bus_clock_line_oe_n, .host_bus_data_line_i, .host_bus_data_line_o,
    .host_bus_data_line_oe_n, .reg_wr, .reg_rd_addr, .reg_rd_data, .reg_rd_strobe,
    .bypass_stretch, .results_ready, .host_event_irq, .pointer);
  ihrp_host_model ihrp_host_model_inst (.sda(host_bus_data_line_i), .scl_low(h_scl),
    .sda_low(h_sda));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  // Register file behind the port
  always @(posedge clk) begin
    if (reg_wr.wr === 1'b1) begin
      regs[reg_wr.addr] <= reg_wr.data;
      wr_cnt++;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [7:0] d, input logic ea);
    logic [7:0] q;
    logic k;
    ihrp_host_model_inst.byte_io(d, 1'b1, q, k);
    chk({7'h00, k}, {7'h00, ea});
  endtask : send
  task automatic recv(input logic [7:0] e, input logic last);
    logic [7:0] q;
    logic k;
    ihrp_host_model_inst.byte_io(8'hFF, last, q, k);
    chk(q, e);
  endtask : recv
  // Burst write across the pointer wrap
  task automatic t_write();
    ihrp_host_model_inst.start();
    send(8'h50, 1'b0);
    send(8'hFE, 1'b0);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    send(8'h33, 1'b0);
    ihrp_host_model_inst.stop();
    chk(regs[8'hFE], 8'h11);
    chk(regs[8'hFF], 8'h22);
    chk(regs[8'h00], 8'h33);
    chk(pointer, 8'h01);
  endtask : t_write
  task automatic t_ptr_only();
    int n;
    n = wr_cnt;
    ihrp_host_model_inst.start();
    send(8'h50, 1'b0);
    send(8'h40, 1'b0);
    ihrp_host_model_inst.stop();
    chk(pointer, 8'h40);
    chk(8'(wr_cnt - n), 8'h00);
  endtask : t_ptr_only
  task automatic t_reads();
    ihrp_host_model_inst.start();
    send(8'h50, 1'b0);
    send(8'hFF, 1'b0);
    ihrp_host_model_inst.start();
    send(8'h51, 1'b0);
    recv(8'h22, 1'b1);
    ihrp_host_model_inst.stop();
    // Fresh read continues from the wrapped pointer
    ihrp_host_model_inst.start();
    send(8'h51, 1'b0);
    recv(8'h33, 1'b0);
    recv(8'h5B, 1'b1);
    ihrp_host_model_inst.stop();
  endtask : t_reads
  // Neighbour address must be ignored entirely
  task automatic t_bad_addr();
    int n;
    n = wr_cnt;
    ihrp_host_model_inst.start();
    send(8'h52, 1'b1);
    send(8'h77, 1'b1);
    ihrp_host_model_inst.stop();
    chk(8'(wr_cnt - n), 8'h00);
  endtask : t_bad_addr
  task automatic t_irq();
    @(negedge clk) results_ready = 1'b1;
    @(negedge clk) chk({7'h00, host_event_irq}, 8'h01);
    results_ready = 1'b0;
    @(negedge clk) chk({7'h00, host_event_irq}, 8'h00);
  endtask : t_irq
  // Pass-through hold: clock kept low only while bypass stands
  task automatic t_stretch();
    @(negedge clk) bypass_stretch = 1'b1;
    @(negedge clk) chk({7'h00, host_bus_clock_line_oe_n}, 8'h01);
    ihrp_host_model_inst.drive_scl(1'b1);
    repeat (4) @(negedge clk);
    ihrp_host_model_inst.drive_scl(1'b0);
    repeat (2) @(negedge clk);
    chk({7'h00, host_bus_clock_line_i}, 8'h00);
    bypass_stretch = 1'b0;
    @(negedge clk) chk({7'h00, host_bus_clock_line_oe_n}, 8'h01);
    repeat (4) @(negedge clk);
    chk({7'h00, host_bus_clock_line_i}, 8'h01);
  endtask : t_stretch
  task automatic test_done();
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i) ^ 8'h5A;
    end
    rst_n = 1'b0;
    bypass_stretch = 1'b0;
    results_ready = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    t_write();
    t_ptr_only();
    t_reads();
    t_bad_addr();
    t_irq();
    t_stretch();
    test_done();
  end
  // Whole run needs about 20 us
  initial begin
    #200us;
    fails++;
    test_done();
  end
endmodule : test_i2c_host_register_port
